// [design/cic_pkg.sv]
// Package for the core interrupt control block: map, fields, timing.
`default_nettype none
package cic_pkg;
    // Avalon word byte addresses of the block's registers.
    localparam logic [3:0] CIC_ADDR_CORE = 4'h0;     // core_irq_control_reg
    localparam logic [3:0] CIC_ADDR_PFLAG_A = 4'h4;  // peripheral_flag_reg_a
    localparam logic [3:0] CIC_ADDR_PFLAG_B = 4'h8;  // peripheral_flag_reg_b
    localparam logic [3:0] CIC_ADDR_PEN_A = 4'hC;    // peripheral_enable_reg_a
    localparam logic [3:0] CIC_ADDR_PEN_B = 4'h0;    // word 4, see high bit
    localparam logic CIC_HI_B = 1'b1;                 // selects 0x10 / 0x14
    localparam logic [3:0] CIC_ADDR_OPT = 4'h4;      // option, at 0x14
    // Core control register bit positions.
    localparam int CIC_B_GIE = 7;
    localparam int CIC_B_PERIPHERAL_GROUP_IRQ_ENABLE = 6;
    localparam int CIC_B_TMR_EN = 5;
    localparam int CIC_B_EXT_EN = 4;
    localparam int CIC_B_PORT_EN = 3;
    localparam int CIC_B_TMR_FLG = 2;
    localparam int CIC_B_EXT_FLG = 1;
    localparam int CIC_B_PORT_FLG = 0;
    // Reset values.
    localparam logic [7:0] CIC_RST_BYTE = 8'h00;
    localparam logic [12:0] CIC_VECTOR = 13'h0004;
    localparam logic [12:0] CIC_PC_RST = 13'h0000;
    // Instruction-cycle clock and latency of the redirect.
    localparam int CIC_CLK_HZ = 10_000_000;
    localparam int CIC_LAT_CYC = 3;   // Q1 sample to redirect pulse
    // Phases of one instruction cycle.
    typedef enum logic [3:0] {
        CIC_Q1 = 4'b0001,
        CIC_Q2 = 4'b0010,
        CIC_Q3 = 4'b0100,
        CIC_Q4 = 4'b1000
    } cic_phase_t;
    // Core sequencer handshake carried as one bundle.
    typedef struct packed {
        logic redirect;      // flush, push pc, load vector
        logic [12:0] vector;
        logic wake;          // leave sleep
    } cic_core_req_t;
endpackage : cic_pkg
`default_nettype wire

// [design/cic_sync.sv]
// Two-stage synchroniser with an active-edge detector behind it.
`default_nettype none
module cic_sync
    import cic_pkg::*;
(
    input wire logic mclk_i,     // Instruction clock.
    input wire logic reset_i,    // Asynchronous reset.
    input wire logic pin_i,      // Asynchronous pin.
    input wire logic rise_sel_i, // High selects rising edge.
    output logic edge_o          // One-cycle active-edge pulse.
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    // The first stage feeds only the second stage.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    // Edge polarity chosen by the select bit.
    assign edge_o = rise_sel_i ? (sync_q & ~last_q) : (~sync_q & last_q);
endmodule : cic_sync
`default_nettype wire

// [design/cic_avs.sv]
// Avalon-MM slave front end: one waitrequest cycle, registered read data.
`default_nettype none
module cic_avs
    import cic_pkg::*;
(
    input wire logic mclk_i,          // Clock.
    input wire logic reset_i,         // Asynchronous reset.
    input wire logic read_i,          // Avalon read.
    input wire logic write_i,         // Avalon write.
    input wire logic [31:0] rmux_i,   // Selected read value.
    output logic waitrequest_o,       // Low on the accepting edge.
    output logic [31:0] readdata_o,   // Read data.
    output logic wr_stb_o             // Write takes effect this edge.
);
    logic wait_q;
    logic [31:0] rd_q;
    // One wait cycle gives the read mux a full cycle before data stands.
    // Waitrequest is kept as its own flop so the pin has no gate behind it.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_q <= 1'b1;
            rd_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~((read_i | write_i) & wait_q);
            if (read_i & wait_q) begin
                rd_q <= rmux_i;
            end
        end
    end
    assign waitrequest_o = wait_q;
    assign readdata_o = rd_q;
    assign wr_stb_o = write_i & ~wait_q;
endmodule : cic_avs
`default_nettype wire

// [design/cic_top.sv]
// Core interrupt control: flags, enables, redirect, return and wake.
// What this block does
// - Every reset clears all enables, so interrupts start disabled.
// - Request needs global and own enable; peripheral sources also need the group enable.
// - Flags latch on events regardless of any enable.
// - Jump flushes prefetch, clears global enable, pushes PC, loads 0004h.
// - With global enable clear, flags only; pending taken when set again.
// - Return instruction pops PC and sets global enable together.
// - Synchronous source: redirect three cycles after the Q1 sample that takes its flag.
// - Asynchronous source: same, but the two synchroniser stages set its flag two cycles later.
// - Latency is the same for one- and two-cycle instructions.
// - Pin flag may set during Q4-Q1, sampled every Q1.
// - Enabled clockless source wakes sleep; vector only if global enable.
// - After wake, the instruction after sleep runs before the branch.
// - Pin interrupt is edge triggered; select bit picks rise or fall.
// - Active edge sets pin flag; redirect needs global and pin enable.
// - Only the return PC is saved; other core registers untouched.
// - Loading the vector leaves the PC upper latch unchanged.
// - Global enable bit 7, group enable bit 6, reset zero, R/W.
// - Pin flag at bit 1, pin enable at bit 4.
`default_nettype none
module cic_top
    import cic_pkg::*;
#(
    parameter int PERIPH_W = 8 // Sources per peripheral flag register.
) (
    input wire logic mclk_i,                      // Instruction clock.
    input wire logic reset_i,                     // Any device reset.
    input wire logic [4:0] avs_address_i,         // Avalon byte address.
    input wire logic avs_read_i,                  // Avalon read.
    input wire logic avs_write_i,                 // Avalon write.
    input wire logic [31:0] avs_writedata_i,      // Avalon write data.
    output logic [31:0] avs_readdata_o,           // Avalon read data.
    output logic avs_waitrequest_o,               // Avalon waitrequest.
    input wire logic ext_pin_i,                   // External interrupt pin.
    input wire logic tmr_evt_i,                   // Timer overflow pulse.
    input wire logic port_evt_i,                  // Port change pulse.
    input wire logic [PERIPH_W-1:0] periph_a_evt_i, // Group A pulses.
    input wire logic [PERIPH_W-1:0] periph_b_evt_i, // Group B pulses.
    input wire logic [PERIPH_W-1:0] clockless_a_i,  // A bits that run asleep.
    input wire logic [PERIPH_W-1:0] clockless_b_i,  // B bits that run asleep.
    input wire logic insn_done_i,                 // Instruction boundary.
    input wire logic sleep_i,                     // Core is in sleep.
    input wire logic retirq_i,                    // Return instruction done.
    input wire logic [12:0] stack_top_i,          // Popped return address.
    input wire logic [12:0] pc_i,                 // Current PC to save.
    output logic redirect_o,                      // Flush and jump pulse.
    output logic push_o,                          // Push pc_push_o pulse.
    output logic [12:0] pc_push_o,                // Return address pushed.
    output logic [12:0] pc_load_o,                // New PC on load.
    output logic pc_load_o_en_o,                  // Load PC pulse.
    output logic wake_o,                          // Leave sleep pulse.
    output logic [3:0] phase_o                    // Q phase, one cycle late.
);
    logic gie_q, peripheral_group_irq_enable_q, tmr_en_q, ext_en_q, port_en_q;
    logic tmr_f_q, ext_f_q, port_f_q;
    logic [PERIPH_W-1:0] pfa_q, pfb_q, pea_q, peb_q;
    logic edge_sel_q;
    cic_phase_t phase_q;
    logic ext_edge, wr_stb, req, wake_req;
    logic fire, core_we;
    logic [31:0] rmux;
    logic [1:0] lat_q;
    logic pend_q;
    logic post_wake_q;
    cic_core_req_t core_q;
    logic push_q;
    logic [12:0] push_pc_q;
    logic ld_q;
    logic [12:0] ld_pc_q;
    logic [3:0] ph_o_q;

    // Bus slave shell.
    cic_avs u_avs (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .read_i(avs_read_i),
        .write_i(avs_write_i),
        .rmux_i(rmux),
        .waitrequest_o(avs_waitrequest_o),
        .readdata_o(avs_readdata_o),
        .wr_stb_o(wr_stb)
    );

    // Pin is asynchronous, so it is synchronised before edge detection.
    cic_sync u_pin (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .pin_i(ext_pin_i),
        .rise_sel_i(edge_sel_q),
        .edge_o(ext_edge)
    );

    // Address decode helpers.
    function automatic logic hit(input logic [4:0] a, input logic [3:0] lo,
                                 input logic hi);
        hit = (a[3:0] == lo) && (a[4] == hi);
    endfunction : hit

    // Write-with-set-priority: hardware event beats software clear.
    function automatic logic [PERIPH_W-1:0] flg_upd(
        input logic [PERIPH_W-1:0] cur, input logic [PERIPH_W-1:0] evt,
        input logic we, input logic [PERIPH_W-1:0] wd);
        flg_upd = (we ? wd : cur) | evt;
    endfunction : flg_upd

    // Read multiplexer; unmapped words read zero.
    always_comb begin
        rmux = 32'h0000_0000;
        if (hit(avs_address_i, CIC_ADDR_CORE, 1'b0)) begin
            rmux[CIC_B_GIE] = gie_q;
            rmux[CIC_B_PERIPHERAL_GROUP_IRQ_ENABLE] = peripheral_group_irq_enable_q;
            rmux[CIC_B_TMR_EN] = tmr_en_q;
            rmux[CIC_B_EXT_EN] = ext_en_q;
            rmux[CIC_B_PORT_EN] = port_en_q;
            rmux[CIC_B_TMR_FLG] = tmr_f_q;
            rmux[CIC_B_EXT_FLG] = ext_f_q;
            rmux[CIC_B_PORT_FLG] = port_f_q;
        end else if (hit(avs_address_i, CIC_ADDR_PFLAG_A, 1'b0)) begin
            rmux[PERIPH_W-1:0] = pfa_q;
        end else if (hit(avs_address_i, CIC_ADDR_PFLAG_B, 1'b0)) begin
            rmux[PERIPH_W-1:0] = pfb_q;
        end else if (hit(avs_address_i, CIC_ADDR_PEN_A, 1'b0)) begin
            rmux[PERIPH_W-1:0] = pea_q;
        end else if (hit(avs_address_i, CIC_ADDR_PEN_B, CIC_HI_B)) begin
            rmux[PERIPH_W-1:0] = peb_q;
        end else if (hit(avs_address_i, CIC_ADDR_OPT, CIC_HI_B)) begin
            rmux[0] = edge_sel_q;
        end
    end

    // Q-phase ring marks where Q1 sampling happens.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_q <= CIC_Q1;
        end else begin
            case (phase_q)
                CIC_Q1: phase_q <= CIC_Q2;
                CIC_Q2: phase_q <= CIC_Q3;
                CIC_Q3: phase_q <= CIC_Q4;
                CIC_Q4: phase_q <= CIC_Q1;
                default: phase_q <= CIC_Q1;
            endcase
        end
    end

    // Write decode for the core control word, used only by the
    // global enable update.
    assign core_we = wr_stb && hit(avs_address_i, CIC_ADDR_CORE, 1'b0);

    // The jump fires when the latency count runs out. The global enable is
    // cleared on this same edge: clearing it a cycle later would let the
    // next Q1 sample re-arm the counter and jump a second time.
    assign fire = pend_q && (lat_q == 2'd0);

    // Core enables; all clear under any reset.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            gie_q <= 1'b0;
            peripheral_group_irq_enable_q <= 1'b0;
            tmr_en_q <= 1'b0;
            ext_en_q <= 1'b0;
            port_en_q <= 1'b0;
            edge_sel_q <= 1'b0;
        end else begin
            if (wr_stb && hit(avs_address_i, CIC_ADDR_CORE, 1'b0)) begin
                peripheral_group_irq_enable_q <= avs_writedata_i[CIC_B_PERIPHERAL_GROUP_IRQ_ENABLE];
                tmr_en_q <= avs_writedata_i[CIC_B_TMR_EN];
                ext_en_q <= avs_writedata_i[CIC_B_EXT_EN];
                port_en_q <= avs_writedata_i[CIC_B_PORT_EN];
            end
            if (wr_stb && hit(avs_address_i, CIC_ADDR_OPT, CIC_HI_B)) begin
                edge_sel_q <= avs_writedata_i[0];
            end
            // Redirect clears, return sets; hardware wins over software.
            if (fire) begin
                gie_q <= 1'b0;
            end else if (retirq_i) begin
                gie_q <= 1'b1;
            end else if (core_we) begin
                gie_q <= avs_writedata_i[CIC_B_GIE];
            end
        end
    end

    // Core flags latch regardless of enables; set beats write-clear.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tmr_f_q <= 1'b0;
            ext_f_q <= 1'b0;
            port_f_q <= 1'b0;
        end else begin
            if (wr_stb && hit(avs_address_i, CIC_ADDR_CORE, 1'b0)) begin
                tmr_f_q <= avs_writedata_i[CIC_B_TMR_FLG] | tmr_evt_i;
                ext_f_q <= avs_writedata_i[CIC_B_EXT_FLG] | ext_edge;
                port_f_q <= avs_writedata_i[CIC_B_PORT_FLG] | port_evt_i;
            end else begin
                tmr_f_q <= tmr_f_q | tmr_evt_i;
                ext_f_q <= ext_f_q | ext_edge;
                port_f_q <= port_f_q | port_evt_i;
            end
        end
    end

    // Peripheral flags and enables.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pfa_q <= '0;
            pfb_q <= '0;
            pea_q <= '0;
            peb_q <= '0;
        end else begin
            pfa_q <= flg_upd(pfa_q, periph_a_evt_i,
                wr_stb && hit(avs_address_i, CIC_ADDR_PFLAG_A, 1'b0),
                avs_writedata_i[PERIPH_W-1:0]);
            pfb_q <= flg_upd(pfb_q, periph_b_evt_i,
                wr_stb && hit(avs_address_i, CIC_ADDR_PFLAG_B, 1'b0),
                avs_writedata_i[PERIPH_W-1:0]);
            if (wr_stb && hit(avs_address_i, CIC_ADDR_PEN_A, 1'b0)) begin
                pea_q <= avs_writedata_i[PERIPH_W-1:0];
            end
            if (wr_stb && hit(avs_address_i, CIC_ADDR_PEN_B, CIC_HI_B)) begin
                peb_q <= avs_writedata_i[PERIPH_W-1:0];
            end
        end
    end

    // Request: core terms plus group-gated peripheral terms.
    assign req = gie_q & ((tmr_f_q & tmr_en_q)
        | (ext_f_q & ext_en_q) | (port_f_q & port_en_q)
        | (peripheral_group_irq_enable_q & (|(pfa_q & pea_q) | |(pfb_q & peb_q))));
    // Wake ignores the global enable; only clockless sources count.
    assign wake_req = (ext_f_q & ext_en_q) | (port_f_q & port_en_q)
        | (peripheral_group_irq_enable_q & (|(pfa_q & pea_q & clockless_a_i)
        | |(pfb_q & peb_q & clockless_b_i)));

    // Latency counter runs from Q1 sampling, never from the instruction
    // boundary, so one- and two-cycle instructions see the same delay.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_q <= 1'b0;
            lat_q <= 2'd0;
            post_wake_q <= 1'b0;
            core_q <= '0;
        end else begin
            core_q.redirect <= 1'b0;
            core_q.wake <= 1'b0;
            core_q.vector <= CIC_VECTOR;
            if (sleep_i && wake_req) begin
                core_q.wake <= 1'b1;
                post_wake_q <= gie_q;
            end else if (post_wake_q && insn_done_i) begin
                post_wake_q <= 1'b0;
            end
            if (!pend_q) begin
                // Sampling only in Q1; a masked request just waits.
                if (req && phase_q == CIC_Q1 && !sleep_i && !post_wake_q) begin
                    pend_q <= 1'b1;
                    lat_q <= 2'(CIC_LAT_CYC - 1);
                end
            end else if (lat_q != 2'd0) begin
                lat_q <= lat_q - 2'd1;
            end else begin
                pend_q <= 1'b0;
                core_q.redirect <= 1'b1;
            end
        end
    end

    // Output registers: only the return PC is handed out for saving.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            push_q <= 1'b0;
            push_pc_q <= CIC_PC_RST;
            ld_q <= 1'b0;
            ld_pc_q <= CIC_PC_RST;
            ph_o_q <= CIC_Q1;
        end else begin
            push_q <= core_q.redirect;
            ld_q <= core_q.redirect | retirq_i;
            ph_o_q <= phase_q;
            if (core_q.redirect) begin
                push_pc_q <= pc_i;
                ld_pc_q <= core_q.vector;
            end else if (retirq_i) begin
                ld_pc_q <= stack_top_i;
            end
        end
    end

    // Redirect and wake are registered pulses straight from flops.
    assign redirect_o = core_q.redirect;
    assign wake_o = core_q.wake;
    assign push_o = push_q;
    assign pc_push_o = push_pc_q;
    assign pc_load_o_en_o = ld_q;
    assign pc_load_o = ld_pc_q;
    assign phase_o = ph_o_q;
endmodule : cic_top
`default_nettype wire

// [tb/cic_top_asserts.sv]
// Port checker for the core interrupt control block.
`default_nettype none
module cic_top_asserts
    import cic_pkg::*;
(
    input wire logic mclk_i,             // Clock.
    input wire logic reset_i,            // Reset.
    input wire logic avs_read_i,         // Bus read.
    input wire logic avs_write_i,        // Bus write.
    input wire logic avs_waitrequest_o,  // Bus wait.
    input wire logic sleep_i,            // Core asleep.
    input wire logic retirq_i,           // Return done.
    input wire logic [12:0] stack_top_i, // Popped address.
    input wire logic redirect_o,         // Redirect pulse.
    input wire logic push_o,             // Push pulse.
    input wire logic [12:0] pc_load_o,   // New pc.
    input wire logic pc_load_o_en_o,     // Load pulse.
    input wire logic wake_o,             // Wake pulse.
    input wire logic [3:0] phase_o       // Q phase.
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    // A request is accepted within one cycle of being raised.
    a_bus_ack_soon: assert property (
        (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
        else $error("bus not acknowledged");
    a_push_follows: assert property (redirect_o
        |=> push_o && pc_load_o_en_o) else $error("no push after redirect");
    a_vector_load: assert property (push_o
        |-> pc_load_o == CIC_VECTOR) else $error("vector not loaded");
    a_return_pop: assert property (retirq_i |=> pc_load_o_en_o
        && pc_load_o == $past(stack_top_i)) else $error("return not popped");
    // The global enable is cleared, so no second redirect follows at once.
    a_gie_cleared: assert property (redirect_o
        |=> !redirect_o [*4]) else $error("redirect repeated");
    a_phase_onehot: assert property ($onehot(phase_o))
        else $error("phase not one-hot");
    a_phase_wraps: assert property (phase_o == CIC_Q4
        |-> ##[1:4] phase_o == CIC_Q1) else $error("phase did not wrap");
    a_wake_asleep: assert property (wake_o
        |-> $past(sleep_i)) else $error("wake while awake");

    c_redirect: cover property (redirect_o ##1 push_o);
    c_wake: cover property (wake_o);
    c_return: cover property (retirq_i ##1 pc_load_o_en_o);
endmodule : cic_top_asserts

bind cic_top cic_top_asserts cic_top_asserts_i (.mclk_i, .reset_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .sleep_i, .retirq_i,
    .stack_top_i, .redirect_o, .push_o, .pc_load_o, .pc_load_o_en_o,
    .wake_o, .phase_o);
`default_nettype wire

// [tb/cic_core_model.sv]
// Core sequencer model: program counter, one-deep stack, sleep state.
`default_nettype none
module cic_core_model (
    input wire logic mclk_i,           // Clock.
    input wire logic reset_i,          // Reset.
    input wire logic push_i,           // Save return pc.
    input wire logic [12:0] pc_push_i, // Pushed pc.
    input wire logic load_i,           // Load pc.
    input wire logic [12:0] pc_load_i, // New pc.
    input wire logic wake_i,           // Leave sleep.
    input wire logic ret_i,            // Run a return.
    input wire logic nap_i,            // Enter sleep.
    output logic [12:0] pc_o,          // Current pc.
    output logic [12:0] top_o,         // Stack top.
    output logic done_o,               // Instruction end.
    output logic retirq_o,             // Return done.
    output logic sleep_o               // Asleep.
);
    logic [1:0] cnt_q;

    // Four-cycle instructions; none end while asleep, the next runs on wake.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 2'h0;
            done_o <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            done_o <= (cnt_q == 2'h3) && !sleep_o;
        end
    end

    // Only the return pc is kept; no other core state is saved.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_o <= 13'h0000;
            top_o <= 13'h0000;
        end else begin
            if (push_i) top_o <= pc_push_i;
            if (load_i) pc_o <= pc_load_i;
            else if (done_o) pc_o <= pc_o + 13'h0001;
        end
    end

    // Return and sleep are commanded by the bench and echoed a cycle later.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            retirq_o <= 1'b0;
            sleep_o <= 1'b0;
        end else begin
            retirq_o <= ret_i;
            sleep_o <= nap_i || (sleep_o && !wake_i);
        end
    end
endmodule : cic_core_model
`default_nettype wire

// [tb/core_interrupt_control_tb.sv]
// Self-checking bench for the core interrupt control block.
`default_nettype none
module core_interrupt_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cic_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic tmr = 1'b0;
    logic pin = 1'b0;
    logic ret_q = 1'b0;
    logic nap_q = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [7:0] cla = 8'h00;
    logic [31:0] rdat;
    logic wreq, redirect_o, push_o, ld_en, wake_o, done, rq, slp;
    logic [12:0] pc, top, pc_push, pc_load;
    int miscompares = 0;
    int checked = 0;

    cic_top cic_top_i (.mclk_i, .reset_i, .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .ext_pin_i(pin),
        .tmr_evt_i(tmr), .port_evt_i(tmr), .periph_a_evt_i(pa),
        .periph_b_evt_i(pa), .clockless_a_i(cla),
        .clockless_b_i(8'h00), .insn_done_i(done), .sleep_i(slp),
        .retirq_i(rq), .stack_top_i(top), .pc_i(pc), .redirect_o,
        .push_o, .pc_push_o(pc_push), .pc_load_o(pc_load),
        .pc_load_o_en_o(ld_en), .wake_o, .phase_o());
    cic_core_model cic_core_model_i (.mclk_i, .reset_i, .push_i(push_o),
        .pc_push_i(pc_push), .load_i(ld_en), .pc_load_i(pc_load),
        .wake_i(wake_o), .ret_i(ret_q), .nap_i(nap_q), .pc_o(pc),
        .top_o(top), .done_o(done), .retirq_o(rq), .sleep_o(slp));

    // Free-running 10 MHz clock.
    always #50 mclk_i = ~mclk_i;

    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One bus cycle, held until waitrequest is sampled low.
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        adr <= a;
        wr_s <= w;
        rd_s <= !w;
        wd <= {24'h00_0000, d};
        // Only the watchdog ends a wait that never gets its answer.
        do begin
            @(posedge mclk_i);
        end while (wreq !== 1'b0);
        q = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        chk(q, {24'h00_0000, e});
    endtask : rd

    // One-cycle event pulse on the timer and port sources and on peripheral groups A and B.
    task automatic ev(input logic t, input logic [7:0] m);
        @(posedge mclk_i);
        tmr <= t;
        pa <= m;
        @(posedge mclk_i);
        tmr <= 1'b0;
        pa <= 8'h00;
    endtask : ev

    task automatic core(input logic r, input logic n);
        @(posedge mclk_i);
        ret_q <= r;
        nap_q <= n;
        @(posedge mclk_i);
        ret_q <= 1'b0;
        nap_q <= 1'b0;
    endtask : core

    // Watch redirect (w=0) or wake (w=1) for a bounded window.
    task automatic see(input logic w, input logic e);
        logic s;
        s = 1'b0;
        repeat (16) begin
            @(posedge mclk_i);
            if ((w ? wake_o : redirect_o) === 1'b1) s = 1'b1;
        end
        chk({31'h0000_0000, s}, {31'h0000_0000, e});
    endtask : see

    task automatic t_regs;
        rd(5'h00, 8'h00);
        wr(5'h00, 8'hC0);
        rd(5'h00, 8'hC0);
        wr(5'h00, 8'h10);
        rd(5'h00, 8'h10);
        rd(5'h18, 8'h00);
        wr(5'h00, 8'h00);
    endtask : t_regs

    task automatic t_latch_and_redirect;
        ev(1'b1, 8'h00);
        see(1'b0, 1'b0);
        rd(5'h00, 8'h05);
        ev(1'b0, 8'h08);
        rd(5'h04, 8'h08);
        rd(5'h08, 8'h08);
        wr(5'h04, 8'h00);
        wr(5'h00, 8'hA4);
        see(1'b0, 1'b1);
        rd(5'h00, 8'h24);
        wr(5'h00, 8'h20);
        core(1'b1, 1'b0);
        rd(5'h00, 8'hA0);
        ev(1'b1, 8'h00);
        see(1'b0, 1'b1);
        wr(5'h00, 8'h00);
    endtask : t_latch_and_redirect

    task automatic t_periph;
        wr(5'h0C, 8'h01);
        wr(5'h00, 8'h80);
        ev(1'b0, 8'h01);
        see(1'b0, 1'b0);
        wr(5'h00, 8'hC0);
        see(1'b0, 1'b1);
        wr(5'h04, 8'h00);
        wr(5'h00, 8'h00);
    endtask : t_periph

    // Both edge selections: the wrong edge is ignored, the right one taken.
    task automatic t_pin;
        for (int s = 0; s < 2; s++) begin
            wr(5'h14, 8'(s));
            pin <= 1'(s);
            repeat (8) @(posedge mclk_i);
            wr(5'h00, 8'h00);
            wr(5'h00, 8'h90);
            pin <= !1'(s);
            see(1'b0, 1'b0);
            rd(5'h00, 8'h90);
            pin <= 1'(s);
            see(1'b0, 1'b1);
            rd(5'h00, 8'h12);
            wr(5'h00, 8'h00);
        end
    endtask : t_pin

    task automatic t_wake;
        cla <= 8'h02;
        wr(5'h0C, 8'h02);
        wr(5'h00, 8'h40);
        core(1'b0, 1'b1);
        ev(1'b0, 8'h02);
        see(1'b1, 1'b1);
        see(1'b0, 1'b0);
        // Second sleep with the global enable set: wake, then the vector.
        wr(5'h04, 8'h00);
        wr(5'h00, 8'hC0);
        core(1'b0, 1'b1);
        ev(1'b0, 8'h02);
        see(1'b0, 1'b1);
        rd(5'h00, 8'h40);
        wr(5'h04, 8'h00);
        wr(5'h00, 8'h00);
    endtask : t_wake

    // Main sequence; the whole run needs about 360 cycles.
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_regs();
        t_latch_and_redirect();
        t_periph();
        t_pin();
        t_wake();
        summarize();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        summarize();
    end
endmodule : core_interrupt_control_tb
`default_nettype wire
